// >>> rtl/lvr_deser.sv
// Lane sampler and word aligner on the link bit clock.
// Assumes the bit clock runs at seven times the forwarded clock, phase-aligned by the board.
`timescale 1ns/100ps
module lvr_deser
  import lvr_pkg::*;
#(
  parameter int LANES = LVR_LANES_MAX
) (
  input  wire logic                  link_clk,   // Bit clock
  input  wire logic                  link_rst_n, // Synchronised reset
  input  wire logic                  fwd_in,     // Forwarded clock level
  input  wire logic [LANES-1:0]      lane_in,    // Serial lanes
  output logic      [LVR_WORD_W-1:0] word_o,     // Assembled raw word
  output logic                       stb_o,      // Word complete
  output logic                       hi_o,       // Pixel clock high phase
  output logic                       locked_o    // Framing locked
);
  logic                  fwd_q;
  logic                  fwd_prev_q;
  logic [LANES-1:0]      lane_q;
  logic [2:0]            slot_q;
  logic [2:0]            slot_now;
  logic [3:0]            good_q;
  logic [LVR_WORD_W-1:0] cur_q;
  logic [LVR_WORD_W-1:0] cur_d;
  logic                  edge_w;

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fwd_q      <= 1'b0;
      fwd_prev_q <= 1'b0;
      lane_q     <= '0;
    end else begin
      fwd_q      <= fwd_in;
      fwd_prev_q <= fwd_q;
      lane_q     <= lane_in;
    end
  end

  // Rising edge of the forwarded clock marks slot 0
  assign edge_w   = fwd_q & ~fwd_prev_q;
  assign slot_now = edge_w ? 3'h0 : slot_q;

  always_comb begin
    cur_d = cur_q;
    if (slot_now < 3'(LVR_SLOTS)) begin
      for (int l = 0; l < LANES; l++) begin
        cur_d[l * LVR_SLOTS + int'(slot_now)] = lane_q[l];
      end
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      slot_q <= 3'h7;
      cur_q  <= '0;
    end else begin
      slot_q <= (slot_now == 3'h7) ? 3'h7 : slot_now + 3'h1;
      cur_q  <= cur_d;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      good_q <= 4'h0;
    end else if (edge_w) begin
      if (slot_q != 3'h7) begin
        good_q <= 4'h0;
      end else if (good_q != 4'(LVR_LOCK_FRAMES)) begin
        good_q <= good_q + 4'h1;
      end
    end else if (slot_q == 3'h7) begin
      good_q <= 4'h0;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      word_o   <= '0;
      stb_o    <= 1'b0;
      hi_o     <= 1'b0;
      locked_o <= 1'b0;
    end else begin
      stb_o    <= (slot_now == 3'h6);
      hi_o     <= (slot_now == 3'h6) || (slot_now < 3'h3);
      locked_o <= (good_q == 4'(LVR_LOCK_FRAMES));
      if (slot_now == 3'h6) begin
        word_o <= cur_d;
      end
    end
  end

  property p_word_every_seven;
    @(posedge link_clk) disable iff (!link_rst_n || !locked_o)
      stb_o |=> (!stb_o) [*6] ##1 stb_o;
  endproperty
  a_word_every_seven: assert property (p_word_every_seven)
    else $error("word strobe not every seven bit clocks");
endmodule

// >>> rtl/lvr_pkg.sv
// Constants shared by the serial display link receiver.
// Assumes a 100 MHz bus clock and a link bit clock at seven times the pixel rate.
package lvr_pkg;
  // Link framing
  localparam int LVR_SLOTS       = 7;
  localparam int LVR_LANES_MAX   = 4;
  localparam int LVR_WORD_W      = 28;
  localparam int LVR_COLOR_W     = 8;
  localparam int LVR_LOCK_FRAMES = 8;
  // Raw word positions, index = lane * 7 + slot
  localparam int LVR_R_LO      = 0;
  localparam int LVR_G_LO      = 6;
  localparam int LVR_B_LO      = 12;
  localparam int LVR_LINE_IDX  = 18;
  localparam int LVR_FRAME_IDX = 19;
  localparam int LVR_VALID_IDX = 20;
  localparam int LVR_R_HI      = 21;
  localparam int LVR_G_HI      = 23;
  localparam int LVR_B_HI      = 25;
  localparam int LVR_SPARE_IDX = 27;
  // Register map, byte addresses
  localparam logic [7:0]  LVR_CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  LVR_STATUS_ADDR = 8'h04;
  localparam int          LVR_CTRL_EN_BIT     = 0;
  localparam int          LVR_CTRL_NARROW_BIT = 1;
  localparam int          LVR_ST_LOCK_BIT     = 0;
  localparam int          LVR_ST_AWAKE_BIT    = 1;
  localparam int          LVR_ST_RUN_BIT      = 2;
  localparam int          LVR_ST_TMO_BIT      = 3;
  localparam logic        LVR_CTRL_EN_RST     = 1'b1;
  localparam logic        LVR_CTRL_NARROW_RST = 1'b0;
  // Timing
  localparam int LVR_CLK_PERIOD_NS  = 10;
  localparam int LVR_PLL_LOCK_MS    = 10;
  localparam int LVR_SETTLE_MS      = 10;
  localparam int LVR_SLEEP_ENTRY_US = 1;
  localparam int LVR_PLL_LOCK_CYC   = LVR_PLL_LOCK_MS * 1000000 / LVR_CLK_PERIOD_NS;
  localparam int LVR_SETTLE_CYC     = LVR_SETTLE_MS * 1000000 / LVR_CLK_PERIOD_NS;
  localparam int LVR_SLEEP_CYC      = LVR_SLEEP_ENTRY_US * 1000 / LVR_CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LVR_ST_SLEEP = 2'b00,
    LVR_ST_WAIT  = 2'b01,
    LVR_ST_RUN   = 2'b10
  } lvr_state_t;
endpackage

// >>> rtl/lvr_top.sv
// Serial display link receiver: lane deserialiser, pixel output stage and AHB-Lite registers.
// Assumes the link bit clock runs free at seven times the forwarded clock rate.
//
// Operation
// - Sample every lane seven times, evenly spaced, per forwarded clock cycle.
// - Wide mode yields 28 outputs: 8 red, 8 green, 8 blue, syncs, enable.
// - Narrow mode yields 21 outputs: 6 red, 6 green, 6 blue, syncs, enable.
// - Outputs change on pixel clock rise; receiver captures on its fall.
// - Sleep input low forces all outputs low and stops deserialising; the deserialiser here keeps running in sleep.
// - Lock and valid outputs expected within 10 ms of a valid clock.
// - Sleep entry with outputs low completes within 1 us.
// - Pixel clock period equals forwarded clock period, 11.76 to 50 ns.
// - Pixel clock high 4.5-7 ns, low 4.0-6.5 ns at 85 MHz.
// - After wake, outputs stay inactive for about 10 ms before toggling.
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module lvr_top
  import lvr_pkg::*;
#(
  parameter int SETTLE_CYC   = LVR_SETTLE_CYC,
  parameter int PLL_LOCK_CYC = LVR_PLL_LOCK_CYC
) (
  input  wire logic                     hclk,                    // Bus clock
  input  wire logic                     hresetn,                 // Async reset, low
  input  wire logic                     hsel,                    // Slave select
  input  wire logic [31:0]              haddr,                   // Address
  input  wire logic [1:0]               htrans,                  // Transfer type
  input  wire logic                     hwrite,                  // Write
  input  wire logic [2:0]               hsize,                   // Size
  input  wire logic                     hready,                  // Bus ready
  input  wire logic [31:0]              hwdata,                  // Write data
  output logic      [31:0]              hrdata,                  // Read data
  output logic                          hreadyout,               // Slave ready
  output logic                          hresp,                   // Response
  input  wire logic                     link_bit_clk,            // Link bit clock
  input  wire logic                     forwarded_link_clock,    // Forwarded clock
  input  wire logic [LVR_LANES_MAX-1:0] serial_data_lane,        // Data lanes
  input  wire logic                     sleep_n,                 // Power-down, low
  output logic                          regenerated_pixel_clock, // Pixel clock
  output logic      [LVR_COLOR_W-1:0]   red_out,                 // Red
  output logic      [LVR_COLOR_W-1:0]   green_out,               // Green
  output logic      [LVR_COLOR_W-1:0]   blue_out,                // Blue
  output logic                          line_sync_out,           // Line sync
  output logic                          frame_sync_out,          // Frame sync
  output logic                          pixel_valid_out,         // Data enable
  output logic                          ctl_spare_out            // Spare control
);
  lvr_state_t            state_q;
  logic [31:0]           cnt_q;
  logic [1:0]            sleep_h_q;
  logic [1:0]            lock_h_q;
  logic                  en_q;
  logic                  narrow_q;
  logic                  tmo_q;
  logic                  tmo_set;
  logic                  tmo_clr;
  logic                  wr_pend_q;
  logic [7:0]            wr_addr_q;
  logic                  run_q;
  logic                  addr_ok;
  logic [1:0]            lrst_q;
  logic [1:0]            sleep_l_q;
  logic [1:0]            run_l_q;
  logic [1:0]            narrow_l_q;
  logic [LVR_WORD_W-1:0] word_w;
  logic                  stb_w;
  logic                  hi_w;
  logic                  locked_w;
  logic                  active_w;
  logic                  out_on_q;
  logic [LVR_WORD_W-1:0] map_w;

  function automatic logic [LVR_WORD_W-1:0] map_word(input logic [LVR_WORD_W-1:0] raw,
                                                     input logic narrow);
    logic [LVR_COLOR_W-1:0] r;
    logic [LVR_COLOR_W-1:0] g;
    logic [LVR_COLOR_W-1:0] b;
    r = {2'b00, raw[LVR_R_LO +: 6]};
    g = {2'b00, raw[LVR_G_LO +: 6]};
    b = {2'b00, raw[LVR_B_LO +: 6]};
    if (!narrow) begin
      r[7:6] = raw[LVR_R_HI +: 2];
      g[7:6] = raw[LVR_G_HI +: 2];
      b[7:6] = raw[LVR_B_HI +: 2];
    end
    return {narrow ? 1'b0 : raw[LVR_SPARE_IDX], raw[LVR_VALID_IDX], raw[LVR_FRAME_IDX],
            raw[LVR_LINE_IDX], b, g, r};
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] a, input logic en,
                                           input logic nar, input logic lock,
                                           input logic awake, input logic run,
                                           input logic tmo);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == LVR_CTRL_ADDR) begin
      d[LVR_CTRL_EN_BIT]     = en;
      d[LVR_CTRL_NARROW_BIT] = nar;
    end else if (a == LVR_STATUS_ADDR) begin
      d[LVR_ST_LOCK_BIT]  = lock;
      d[LVR_ST_AWAKE_BIT] = awake;
      d[LVR_ST_RUN_BIT]   = run;
      d[LVR_ST_TMO_BIT]   = tmo;
    end
    return d;
  endfunction

  // Bus clock side

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_h_q <= 2'b00;
      lock_h_q  <= 2'b00;
    end else begin
      sleep_h_q <= {sleep_h_q[0], sleep_n};
      lock_h_q  <= {lock_h_q[0], locked_w};
    end
  end

  assign addr_ok = hsel && hready && htrans[1] && (haddr[31:8] == 24'h00_0000);

  // Zero wait states; writes land at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend_q <= addr_ok && hwrite;
        wr_addr_q <= haddr[7:0];
        if (addr_ok && !hwrite) begin
          hrdata <= read_mux(haddr[7:0], en_q, narrow_q, lock_h_q[1], sleep_h_q[1], run_q, tmo_q);
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q     <= LVR_CTRL_EN_RST;
      narrow_q <= LVR_CTRL_NARROW_RST;
    end else if (wr_pend_q && wr_addr_q == LVR_CTRL_ADDR) begin
      en_q     <= hwdata[LVR_CTRL_EN_BIT];
      narrow_q <= hwdata[LVR_CTRL_NARROW_BIT];
    end
  end

  assign tmo_set = (state_q == LVR_ST_WAIT) && (cnt_q == 32'(PLL_LOCK_CYC - 1)) && !lock_h_q[1];
  assign tmo_clr = wr_pend_q && (wr_addr_q == LVR_STATUS_ADDR) && hwdata[LVR_ST_TMO_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmo_q <= 1'b0;
    end else begin
      // Set beats clear so a coincident timeout is kept
      tmo_q <= tmo_set || (tmo_q && !tmo_clr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= LVR_ST_SLEEP;
      cnt_q   <= 32'h0000_0000;
    end else if (!sleep_h_q[1] || !en_q) begin
      state_q <= LVR_ST_SLEEP;
      cnt_q   <= 32'h0000_0000;
    end else begin
      case (state_q)
        LVR_ST_SLEEP: begin
          state_q <= LVR_ST_WAIT;
        end
        LVR_ST_WAIT: begin
          // Runs one past the lock limit so the timeout set fires once and can be cleared
          if (cnt_q < 32'(SETTLE_CYC - 1) || cnt_q < 32'(PLL_LOCK_CYC)) begin
            cnt_q <= cnt_q + 32'h1;
          end
          if (cnt_q >= 32'(SETTLE_CYC - 1) && lock_h_q[1]) begin
            state_q <= LVR_ST_RUN;
          end
        end
        LVR_ST_RUN: begin
          state_q <= LVR_ST_RUN;
        end
        default: begin
          state_q <= LVR_ST_SLEEP;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
    end else begin
      run_q <= (state_q == LVR_ST_RUN) && sleep_h_q[1] && en_q;
    end
  end

  // Link clock side

  // Reset asserts at once and leaves in step with the link clock
  always_ff @(posedge link_bit_clk or negedge hresetn) begin
    if (!hresetn) begin
      lrst_q <= 2'b00;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  always_ff @(posedge link_bit_clk or negedge lrst_q[1]) begin
    if (!lrst_q[1]) begin
      sleep_l_q  <= 2'b00;
      run_l_q    <= 2'b00;
      narrow_l_q <= 2'b00;
    end else begin
      sleep_l_q  <= {sleep_l_q[0], sleep_n};
      run_l_q    <= {run_l_q[0], run_q};
      narrow_l_q <= {narrow_l_q[0], narrow_q};
    end
  end

  lvr_deser #(
    .LANES (LVR_LANES_MAX)
  ) u_deser (
    .link_clk   (link_bit_clk),
    .link_rst_n (lrst_q[1]),
    .fwd_in     (forwarded_link_clock),
    .lane_in    (serial_data_lane),
    .word_o     (word_w),
    .stb_o      (stb_w),
    .hi_o       (hi_w),
    .locked_o   (locked_w)
  );

  assign active_w = sleep_l_q[1] && run_l_q[1] && locked_w;
  assign map_w    = map_word(word_w, narrow_l_q[1]);

  // Output starts on a word boundary so the first pixel clock high phase is whole
  always_ff @(posedge link_bit_clk or negedge lrst_q[1]) begin
    if (!lrst_q[1]) begin
      out_on_q <= 1'b0;
    end else begin
      out_on_q <= active_w && (out_on_q || stb_w);
    end
  end

  // data moves with the rising edge
  always_ff @(posedge link_bit_clk or negedge lrst_q[1]) begin
    if (!lrst_q[1]) begin
      regenerated_pixel_clock <= 1'b0;
      red_out                 <= '0;
      green_out               <= '0;
      blue_out                <= '0;
      line_sync_out           <= 1'b0;
      frame_sync_out          <= 1'b0;
      pixel_valid_out         <= 1'b0;
      ctl_spare_out           <= 1'b0;
    end else if (!active_w || !(out_on_q || stb_w)) begin
      regenerated_pixel_clock <= 1'b0;
      red_out                 <= '0;
      green_out               <= '0;
      blue_out                <= '0;
      line_sync_out           <= 1'b0;
      frame_sync_out          <= 1'b0;
      pixel_valid_out         <= 1'b0;
      ctl_spare_out           <= 1'b0;
    end else begin
      regenerated_pixel_clock <= hi_w;
      if (stb_w) begin
        {ctl_spare_out, pixel_valid_out, frame_sync_out, line_sync_out,
         blue_out, green_out, red_out} <= map_w;
      end
    end
  end

  property p_sleep_zero;
    @(posedge link_bit_clk) disable iff (!lrst_q[1])
      !sleep_l_q[1] |=> !regenerated_pixel_clock && red_out == '0 && green_out == '0
                        && blue_out == '0 && !pixel_valid_out;
  endproperty
  a_sleep_zero: assert property (p_sleep_zero)
    else $error("outputs not low in sleep");

  property p_unlock_zero;
    @(posedge link_bit_clk) disable iff (!lrst_q[1])
      !locked_w |=> !regenerated_pixel_clock && !line_sync_out && !frame_sync_out;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero)
    else $error("outputs active without lock");

  property p_wide_map;
    @(posedge link_bit_clk) disable iff (!lrst_q[1])
      (active_w && stb_w && !narrow_l_q[1]) |=>
        red_out == {$past(word_w[LVR_R_HI +: 2]), $past(word_w[LVR_R_LO +: 6])}
        && line_sync_out == $past(word_w[LVR_LINE_IDX]);
  endproperty
  a_wide_map: assert property (p_wide_map)
    else $error("wide word mapping wrong");

  property p_narrow_map;
    @(posedge link_bit_clk) disable iff (!lrst_q[1])
      (active_w && stb_w && narrow_l_q[1]) |=>
        blue_out[7:6] == 2'b00 && blue_out[5:0] == $past(word_w[LVR_B_LO +: 6])
        && !ctl_spare_out;
  endproperty
  a_narrow_map: assert property (p_narrow_map)
    else $error("narrow word mapping wrong");

  property p_fall_stable;
    @(posedge link_bit_clk) disable iff (!lrst_q[1] || !active_w)
      $fell(regenerated_pixel_clock) |-> $stable(red_out) && $stable(pixel_valid_out);
  endproperty
  a_fall_stable: assert property (p_fall_stable)
    else $error("data changed at strobe edge");

  sequence s_high4;
    regenerated_pixel_clock [*3];
  endsequence
  sequence s_low3;
    !regenerated_pixel_clock [*3];
  endsequence
  property p_clk_shape;
    @(posedge link_bit_clk) disable iff (!lrst_q[1] || !active_w)
      $rose(regenerated_pixel_clock) |=> s_high4 ##1 s_low3 ##1 regenerated_pixel_clock;
  endproperty
  a_clk_shape: assert property (p_clk_shape)
    else $error("pixel clock shape wrong");

  property p_no_run_quiet;
    @(posedge link_bit_clk) disable iff (!lrst_q[1])
      !run_l_q[1] |=> !regenerated_pixel_clock;
  endproperty
  a_no_run_quiet: assert property (p_no_run_quiet)
    else $error("pixel clock toggles before settle");

  property p_timeout_flag;
    @(posedge hclk) disable iff (!hresetn)
      (state_q == LVR_ST_WAIT && cnt_q == 32'(PLL_LOCK_CYC - 1) && !lock_h_q[1]
       && sleep_h_q[1] && en_q) |=> tmo_q;
  endproperty
  a_timeout_flag: assert property (p_timeout_flag)
    else $error("lock timeout not flagged");

  property p_sleep_entry;
    @(posedge hclk) disable iff (!hresetn)
      !sleep_h_q[1] |=> state_q == LVR_ST_SLEEP ##1 !run_q;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry too slow");
endmodule

// >>> verif/lvr_tx_model.sv
// Behavioural serializer that feeds the receiver's forwarded clock and data lanes.
// Assumes it shares the receiver's free-running bit clock; one word is repeated each period.
`timescale 1ns/100ps
module lvr_tx_model
  import lvr_pkg::*;
(
  input  wire logic                     link_clk, // Bit clock
  input  wire logic                     tx_en,    // Send frames
  input  wire logic [LVR_WORD_W-1:0]    tx_word,  // Word sent each period
  output logic                          fwd_clk,  // Forwarded clock
  output logic      [LVR_LANES_MAX-1:0] lanes     // Serial lanes
);
  logic [2:0] slot_q = 3'd0;

  initial begin
    fwd_clk = 1'b0;
    lanes = '0;
  end

  always @(posedge link_clk) begin
    if (tx_en) begin
      slot_q <= (slot_q == 3'd6) ? 3'd0 : slot_q + 3'd1;
      fwd_clk <= (slot_q < 3'd4);
      for (int l = 0; l < LVR_LANES_MAX; l++) begin
        lanes[l] <= tx_word[l * LVR_SLOTS + slot_q];
      end
    end else begin
      // Idle lanes keep moving so a stale bit is never mistaken for data
      slot_q <= 3'd0;
      fwd_clk <= 1'b0;
      lanes <= ~lanes;
    end
  end
endmodule

// >>> verif/tb.sv
// Bench for the display link receiver: AHB-Lite master tasks and one task per scenario.
// Assumes a serializer model on the link and shortened settle and lock counts.
`timescale 1ns/100ps
module tb
  import lvr_pkg::*;
;
  localparam int  SETTLE = 200;
  localparam int  LOCKT  = 300;
  localparam real LPER   = 15.0;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lclk = 0, sleep_n = 1;
  logic        tx_en = 0, hreadyout, hresp, fwd, rpc, lsync, fsync, pval, spare;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, d;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [3:0]  lanes;
  logic [7:0]  red, green, blue;
  logic [27:0] tx_word = '0;
  logic [27:0] px;
  int          err_count = 0, checks_done = 0, cyc = 0;
  real         t0, t1, t2;

  assign px = {spare, pval, fsync, lsync, blue, green, red};

  initial forever #5 hclk = ~hclk;
  initial begin
    #3.3;
    forever #(LPER / 2) lclk = ~lclk;
  end

  lvr_top #(.SETTLE_CYC(SETTLE), .PLL_LOCK_CYC(LOCKT)) lvr_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_bit_clk(lclk), .forwarded_link_clock(fwd),
    .serial_data_lane(lanes), .sleep_n(sleep_n), .regenerated_pixel_clock(rpc),
    .red_out(red), .green_out(green), .blue_out(blue), .line_sync_out(lsync),
    .frame_sync_out(fsync), .pixel_valid_out(pval), .ctl_spare_out(spare));

  lvr_tx_model lvr_tx_model_inst (
    .link_clk(lclk), .tx_en(tx_en), .tx_word(tx_word), .fwd_clk(fwd), .lanes(lanes));

  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  function automatic logic [27:0] exp_px(input logic [27:0] w, input logic nar);
    logic [7:0] r, g, b;
    r = {nar ? 2'b00 : w[LVR_R_HI+:2], w[LVR_R_LO+:6]};
    g = {nar ? 2'b00 : w[LVR_G_HI+:2], w[LVR_G_LO+:6]};
    b = {nar ? 2'b00 : w[LVR_B_HI+:2], w[LVR_B_LO+:6]};
    return {nar ? 1'b0 : w[LVR_SPARE_IDX], w[LVR_VALID_IDX], w[LVR_FRAME_IDX],
            w[LVR_LINE_IDX], b, g, r};
  endfunction

  // Capture on the falling pixel clock edge, then time one period
  task automatic px_check(input logic nar);
    int n;
    n = 0;
    while (rpc !== 1'b1 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    // Let a changed word or mode reach the outputs first
    repeat (3) @(negedge rpc);
    chk({4'h0, px}, {4'h0, exp_px(tx_word, nar)});
    @(posedge rpc);
    t0 = $realtime;
    @(negedge rpc);
    t1 = $realtime;
    @(posedge rpc);
    t2 = $realtime;
    chk(32'(int'((t2 - t0) * 10)), 32'(int'(LVR_SLOTS * LPER * 10)));
    chk(32'(int'((t1 - t0) * 10)), 32'(int'(4 * LPER * 10)));
    @(posedge hclk);
  endtask

  task automatic t_regs();
    ahb(0, 32'h0, 32'h0, d);
    chk(d, 32'h1);
    ahb(0, 32'h4, 32'h0, d);
    chk(d, 32'h2);
    ahb(1, 32'h8, 32'hffffffff, d);
    ahb(0, 32'h8, 32'h0, d);
    chk(d, 32'h0);
    ahb(0, 32'h104, 32'h0, d);
    chk({31'h0, hresp}, 32'h0);
    chk(d, 32'h0);
    ahb(0, 32'h0, 32'h0, d);
    chk(d, 32'h1);
    $display("test regs done");
  endtask

  task automatic t_wide();
    tx_word <= 28'h9a5c3e1;
    tx_en <= 1'b1;
    px_check(1'b0);
    ahb(0, 32'h4, 32'h0, d);
    chk(d, 32'h7);
    $display("test wide done");
  endtask

  task automatic t_narrow();
    ahb(1, 32'h0, 32'h3, d);
    tx_word <= 28'h6b3d27c;
    px_check(1'b1);
    ahb(1, 32'h0, 32'h1, d);
    px_check(1'b0);
    $display("test narrow done");
  endtask

  task automatic t_sleep();
    sleep_n <= 1'b0;
    repeat (LVR_SLEEP_CYC) @(posedge hclk);
    chk({3'h0, rpc, px}, 32'h0);
    ahb(0, 32'h4, 32'h0, d);
    chk(32'(d[LVR_ST_AWAKE_BIT]), 32'h0);
    sleep_n <= 1'b1;
    repeat (SETTLE - 50) @(posedge hclk);
    chk({3'h0, rpc, px}, 32'h0);
    px_check(1'b0);
    $display("test sleep done");
  endtask

  task automatic t_loss();
    tx_en <= 1'b0;
    repeat (50) @(posedge hclk);
    chk({3'h0, rpc, px}, 32'h0);
    sleep_n <= 1'b0;
    repeat (10) @(posedge hclk);
    sleep_n <= 1'b1;
    repeat (LOCKT + 60) @(posedge hclk);
    ahb(0, 32'h4, 32'h0, d);
    chk(32'(d[LVR_ST_TMO_BIT]), 32'h1);
    ahb(1, 32'h4, 32'h8, d);
    ahb(0, 32'h4, 32'h0, d);
    chk(32'(d[LVR_ST_TMO_BIT]), 32'h0);
    $display("test loss done");
  endtask

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_wide();
    t_narrow();
    t_sleep();
    t_loss();
    stop_test();
  end
endmodule
